// ===== common/qcount_pkg.sv
package qcount_pkg;

   // ****************************************************************
   // Register bus geometry.
   // ****************************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // ****************************************************************
   // Register offsets.
   // ****************************************************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_TIMEBASE = 4'h1;
   localparam logic [3:0] ADDR_HI_REQ = 4'h2;
   localparam logic [3:0] ADDR_LO_REQ = 4'h3;
   localparam logic [3:0] ADDR_CMD = 4'h4;
   localparam logic [3:0] ADDR_ON_PRESET = 4'h5;
   localparam logic [3:0] ADDR_OFF_PRESET = 4'h6;
   localparam logic [3:0] ADDR_PRELOAD = 4'h7;
   localparam logic [3:0] ADDR_ACCUM = 4'h8;
   localparam logic [3:0] ADDR_STROBE = 4'h9;
   localparam logic [3:0] ADDR_RATE = 4'hA;
   localparam logic [3:0] ADDR_STATUS = 4'hB;
   localparam logic [3:0] ADDR_HI_LIMIT = 4'hC;
   localparam logic [3:0] ADDR_LO_LIMIT = 4'hD;

   // ****************************************************************
   // Commands, answers and status field positions.
   // ****************************************************************
   localparam logic [15:0] CMD_SET_LIMITS = 16'h0001;
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_LIMIT = 2'h1;
   localparam int STAT_PRELOAD_BIT = 0;
   localparam int STAT_ERR_LSB = 1;
   localparam int STAT_OUT_BIT = 3;

   // ****************************************************************
   // Reset values.
   // ****************************************************************
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] TB_DEFAULT_MS = 16'h03E8;
   localparam logic [15:0] TB_MIN_MS = 16'h000A;
   localparam logic signed [15:0] HI_RESET = 16'sh7FFF;
   localparam logic signed [15:0] LO_RESET = 16'sh0000;
   localparam logic signed [15:0] ON_RESET = 16'sh7FFF;
   localparam logic signed [15:0] OFF_RESET = 16'sh0000;
   localparam logic signed [15:0] PRELOAD_RESET = 16'sh0000;

   // ****************************************************************
   // Timing.
   // ****************************************************************
   localparam int CLOCK_MHZ = 50;
   localparam int MS_TIME_US = 1000;
   localparam int MS_CYCLES_DEFAULT = MS_TIME_US * CLOCK_MHZ;
   localparam int MAX_RATE_HZ = 5000;

   // ****************************************************************
   // Control register layout, bit 0 at the bottom.
   // ****************************************************************
   typedef struct packed {
      logic [6:0] spare;
      logic dir_ignored;
      logic edge_ignored;
      logic mode_ignored;
      logic run;
      logic user_out;
      logic strobe_neg;
      logic strobe_sel;
      logic out_en;
      logic enable;
   } ctrl_t;

   typedef struct packed {
      logic a;
      logic b;
   } phase_t;

endpackage

// ===== verilog/quadrature_counter.sv
// What this block does
// (RQ1) Count once on each rise and fall of either phase, four per cycle.
// (RQ2) Count up when A leads B, down when A lags B.
// (RQ3) Channel holds 16-bit accumulator, strobe capture and rate registers.
// (RQ4) Counts correctly up to 5 kHz; the encoder stays below that.
// (RQ5) Count mode, edge and direction settings are stored but ignored.
// (RQ6) Disabled channel is idle and hands its output to the user; a stop to run write still loads the preload value while disabled.
// (RQ7) Output enable gives the output to the counter, else to the user.
// (RQ8) Preload selected: active input edge loads the preload value.
// (RQ9) Strobe selected: active input edge captures the accumulator.
// (RQ10) Counter runs continuously, wrapping past high to low and back.
// (RQ11) At a limit, opposite counts move the accumulator off normally.
// (RQ12) Preload/strobe active edge selectable, rising edge by default.
// (RQ13) Interval programmable 10 to 65535 ms, 1000 ms after reset.
// (RQ14) Interval end stores signed 16-bit net count, wrapping on overflow.
// (RQ15) Interval value is net displacement, not total edges.
// (RQ16) Limit command demands high and low bound presets, preload, count.
// (RQ17) Bad limits are refused, old kept, limit error code returned.
// (RQ18) Limits are signed values from -32768 to +32767.
// (RQ19) Output window between presets follows which preset is lower.
// (RQ20) Counting changes output one past a preset, either direction.
// (RQ21) Preload loads evaluate the output with no one-count offset.
// (RQ22) Stop to run loads the preload value, zero by default.
// (RQ23) Each input-edge preload load sets a flag software can read; the stop to run load does not.
// (RQ24) Reconfiguration clears the interval value, except preset or preload.
// (RQ25) Phases are synchronised; double changes are dropped as invalid.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ns
module quadrature_counter
   import qcount_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEFAULT
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic phase_a_i,
   input wire logic phase_b_i,
   input wire logic preload_strobe_input_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   output logic counter_driven_output_o
);

   localparam int MS_W = $clog2(MS_CYCLES);

   // ****************************************************************
   // State.
   // ****************************************************************
   ctrl_t ctrl_q;
   logic [15:0] tb_q;
   logic signed [15:0] hi_q, lo_q, hi_req_q, lo_req_q;
   logic signed [15:0] on_q, off_q, pre_q;
   logic signed [15:0] acc_q, strobe_q, rate_q, delta_q;
   logic [1:0] err_q;
   logic pre_flag_q, out_state_q, run_prev_q;
   phase_t ph_s1_q, ph_s2_q, ph_prev_q;
   logic ps_s1_q, ps_s2_q, ps_prev_q;
   logic [MS_W-1:0] ms_cnt_q;
   logic [15:0] tb_cnt_q;

   // ****************************************************************
   // Decode.
   // ****************************************************************
   logic active, run_start, ps_event, load_evt, strobe_evt;
   logic step_up, step_dn, cnt_up, cnt_dn, valid_step;
   logic wr_ctrl, wr_tb, wr_cmd, set_limits, limits_ok, cfg_wr;
   logic ms_tick, tb_end;
   logic signed [15:0] acc_inc, acc_dec;

   function automatic logic out_window(input logic signed [16:0] v,
                                       input logic signed [15:0] on_p,
                                       input logic signed [15:0] off_p);
      logic signed [16:0] on_x;
      logic signed [16:0] off_x;
      on_x = {on_p[15], on_p};
      off_x = {off_p[15], off_p};
      if (on_p <= off_p) begin
         return (v > on_x) && (v <= off_x); // RQ19
      end else begin
         return !((v > off_x) && (v <= on_x)); // RQ19
      end
   endfunction

   always_comb begin
      active = ctrl_q.enable && ctrl_q.run; // RQ6
      run_start = ctrl_q.run && !run_prev_q;
      // Mode, edge and direction bits are never looked at here.
      ps_event = ctrl_q.strobe_neg ? (ps_prev_q && !ps_s2_q)
                                   : (!ps_prev_q && ps_s2_q); // RQ12 RQ5
      load_evt = active && ps_event && !ctrl_q.strobe_sel; // RQ8
      strobe_evt = active && ps_event && ctrl_q.strobe_sel; // RQ9
      valid_step = (ph_s2_q.a != ph_prev_q.a) ^
                   (ph_s2_q.b != ph_prev_q.b); // RQ25 RQ1
      // A leading B walks 00, 10, 11, 01 and back to 00.
      step_up = valid_step && ((ph_s2_q.a ^ ph_prev_q.b) == 1'b1); // RQ2
      step_dn = valid_step && ((ph_s2_q.a ^ ph_prev_q.b) == 1'b0); // RQ2
      cnt_up = active && step_up && !load_evt && !run_start;
      cnt_dn = active && step_dn && !load_evt && !run_start;
      acc_inc = (acc_q == hi_q) ? lo_q : acc_q + 16'sd1; // RQ10 RQ11
      acc_dec = (acc_q == lo_q) ? hi_q : acc_q - 16'sd1; // RQ10 RQ11
      wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
      wr_tb = wr_i && (addr_i == ADDR_TIMEBASE);
      wr_cmd = wr_i && (addr_i == ADDR_CMD);
      set_limits = wr_cmd && (wdata_i == CMD_SET_LIMITS);
      limits_ok = (hi_req_q >= lo_req_q) && (hi_req_q >= on_q) &&
                  (hi_req_q >= off_q) && (hi_req_q >= pre_q) &&
                  (hi_req_q >= acc_q) && (lo_req_q <= on_q) &&
                  (lo_req_q <= off_q) && (lo_req_q <= pre_q) &&
                  (lo_req_q <= acc_q); // RQ16
      cfg_wr = wr_ctrl || wr_tb || wr_cmd; // RQ24
      ms_tick = (ms_cnt_q == MS_W'(MS_CYCLES - 1));
      tb_end = ms_tick && (tb_cnt_q == tb_q - 16'h0001); // RQ13
   end

   // ****************************************************************
   // Input synchronisers.
   // ****************************************************************
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ph_s1_q <= '0;
         ph_s2_q <= '0;
         ph_prev_q <= '0;
      end else begin
         ph_s1_q <= '{a: phase_a_i, b: phase_b_i}; // RQ25
         ph_s2_q <= ph_s1_q; // RQ25
         ph_prev_q <= ph_s2_q; // RQ4
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ps_s1_q <= 1'b0;
         ps_s2_q <= 1'b0;
         ps_prev_q <= 1'b0;
         run_prev_q <= 1'b0;
      end else begin
         ps_s1_q <= preload_strobe_input_i;
         ps_s2_q <= ps_s1_q;
         ps_prev_q <= ps_s2_q;
         run_prev_q <= ctrl_q.run;
      end
   end

   // ****************************************************************
   // Configuration registers.
   // ****************************************************************
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q <= ctrl_t'(CTRL_RESET);
         tb_q <= TB_DEFAULT_MS; // RQ13
         on_q <= ON_RESET;
         off_q <= OFF_RESET;
         pre_q <= PRELOAD_RESET; // RQ22
         hi_req_q <= HI_RESET;
         lo_req_q <= LO_RESET;
      end else if (wr_i) begin
         case (addr_i)
            ADDR_CTRL: ctrl_q <= ctrl_t'(wdata_i); // RQ5
            ADDR_TIMEBASE: begin
               tb_q <= (wdata_i < TB_MIN_MS) ? TB_MIN_MS : wdata_i; // RQ13
            end
            ADDR_HI_REQ: hi_req_q <= $signed(wdata_i); // RQ18
            ADDR_LO_REQ: lo_req_q <= $signed(wdata_i); // RQ18
            ADDR_ON_PRESET: on_q <= $signed(wdata_i);
            ADDR_OFF_PRESET: off_q <= $signed(wdata_i);
            ADDR_PRELOAD: pre_q <= $signed(wdata_i);
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hi_q <= HI_RESET;
         lo_q <= LO_RESET;
         err_q <= ERR_NONE;
      end else if (set_limits) begin
         if (limits_ok) begin
            hi_q <= hi_req_q;
            lo_q <= lo_req_q;
            err_q <= ERR_NONE;
         end else begin
            err_q <= ERR_LIMIT; // RQ17
         end
      end
   end

   // ****************************************************************
   // Accumulator, strobe capture and output state.
   // ****************************************************************
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_q <= PRELOAD_RESET;
         out_state_q <= 1'b0;
      end else if (run_start || load_evt) begin
         acc_q <= pre_q; // RQ22 RQ8
         out_state_q <= out_window({pre_q[15], pre_q}, on_q, off_q); // RQ21
      end else if (cnt_up) begin
         acc_q <= acc_inc; // RQ1 RQ10
         out_state_q <= out_window({acc_inc[15], acc_inc},
                                   on_q, off_q); // RQ20
      end else if (cnt_dn) begin
         acc_q <= acc_dec; // RQ1 RQ10
         out_state_q <= out_window({acc_dec[15], acc_dec} + 17'sd1,
                                   on_q, off_q); // RQ20
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         strobe_q <= '0;
      end else if (strobe_evt) begin
         strobe_q <= acc_q; // RQ9
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pre_flag_q <= 1'b0;
      end else if (load_evt) begin
         pre_flag_q <= 1'b1; // RQ23
      end else if (wr_i && (addr_i == ADDR_STATUS) &&
                   wdata_i[STAT_PRELOAD_BIT]) begin
         pre_flag_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Interval measurement.
   // ****************************************************************
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ms_cnt_q <= '0;
         tb_cnt_q <= '0;
      end else if (cfg_wr || !active) begin
         ms_cnt_q <= '0;
         tb_cnt_q <= '0;
      end else if (ms_tick) begin
         ms_cnt_q <= '0;
         tb_cnt_q <= tb_end ? 16'h0000 : tb_cnt_q + 16'h0001;
      end else begin
         ms_cnt_q <= ms_cnt_q + MS_W'(1);
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         delta_q <= '0;
         rate_q <= '0;
      end else if (cfg_wr) begin
         delta_q <= '0;
         rate_q <= '0; // RQ24
      end else if (active && tb_end) begin
         rate_q <= delta_q + (cnt_up ? 16'sd1 : 16'sd0)
                   - (cnt_dn ? 16'sd1 : 16'sd0); // RQ14 RQ15
         delta_q <= '0;
      end else if (cnt_up) begin
         delta_q <= delta_q + 16'sd1; // RQ15
      end else if (cnt_dn) begin
         delta_q <= delta_q - 16'sd1; // RQ15
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         counter_driven_output_o <= 1'b0;
      end else if (ctrl_q.enable && ctrl_q.out_en) begin
         counter_driven_output_o <= out_state_q; // RQ7
      end else begin
         counter_driven_output_o <= ctrl_q.user_out; // RQ6 RQ7
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         case (addr_i)
            ADDR_CTRL: rdata_o <= ctrl_q;
            ADDR_TIMEBASE: rdata_o <= tb_q;
            ADDR_HI_REQ: rdata_o <= hi_req_q;
            ADDR_LO_REQ: rdata_o <= lo_req_q;
            ADDR_ON_PRESET: rdata_o <= on_q;
            ADDR_OFF_PRESET: rdata_o <= off_q;
            ADDR_PRELOAD: rdata_o <= pre_q;
            ADDR_ACCUM: rdata_o <= acc_q; // RQ3
            ADDR_STROBE: rdata_o <= strobe_q; // RQ3
            ADDR_RATE: rdata_o <= rate_q; // RQ3
            ADDR_STATUS: begin
               rdata_o <= '0;
               rdata_o[STAT_PRELOAD_BIT] <= pre_flag_q;
               rdata_o[STAT_ERR_LSB+:2] <= err_q; // RQ17
               rdata_o[STAT_OUT_BIT] <= out_state_q;
            end
            ADDR_HI_LIMIT: rdata_o <= hi_q;
            ADDR_LO_LIMIT: rdata_o <= lo_q;
            default: rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!reset_n_i);

   a_count_up_step: assert property ( // RQ2
      cnt_up && (acc_q != hi_q) |=> acc_q == $past(acc_q) + 16'sd1)
      else $error("up step did not increment");

   a_wrap_high_low: assert property ( // RQ10
      cnt_up && (acc_q == hi_q) |=> acc_q == $past(lo_q))
      else $error("up wrap did not land on low limit");

   a_wrap_low_high: assert property ( // RQ10
      cnt_dn && (acc_q == lo_q) |=> acc_q == $past(hi_q))
      else $error("down wrap did not land on high limit");

   a_double_change: assert property ( // RQ25
      (ph_s2_q.a != ph_prev_q.a) && (ph_s2_q.b != ph_prev_q.b)
      && !run_start && !load_evt |=> $stable(acc_q))
      else $error("double phase change moved accumulator");

   a_preload_flag: assert property ( // RQ23
      load_evt |=> pre_flag_q && (acc_q == $past(pre_q)))
      else $error("preload did not load and flag");

   a_strobe_copy: assert property ( // RQ9
      strobe_evt |=> strobe_q == $past(acc_q))
      else $error("strobe did not capture accumulator");

   a_limit_reject: assert property ( // RQ17
      set_limits && !limits_ok |=> (err_q == ERR_LIMIT) &&
      $stable(hi_q) && $stable(lo_q))
      else $error("bad limits were taken");

   a_rate_cleared: assert property ( // RQ24
      cfg_wr |=> rate_q == 16'sd0 ##1 rate_q == 16'sd0)
      else $error("reconfiguration left interval value");

   a_user_owns_out: assert property ( // RQ7
      !(ctrl_q.enable && ctrl_q.out_en) |=>
      counter_driven_output_o == $past(ctrl_q.user_out))
      else $error("user output not passed through");

   a_timebase_floor: assert property ( // RQ13
      tb_q >= TB_MIN_MS)
      else $error("interval below minimum");

   a_count_down_step: assert property ( // RQ2
      cnt_dn && (acc_q != lo_q) |=> acc_q == $past(acc_q) - 16'sd1)
      else $error("down step did not decrement");

   a_idle_holds_count: assert property ( // RQ6
      !active && !run_start |=> $stable(acc_q))
      else $error("idle channel moved accumulator");

   a_limit_accept: assert property ( // RQ16
      set_limits && limits_ok |=> (hi_q == $past(hi_req_q)) &&
      (lo_q == $past(lo_req_q)) && (err_q == ERR_NONE))
      else $error("good limits were not taken");

   a_run_start_load: assert property ( // RQ22
      run_start |=> acc_q == $past(pre_q))
      else $error("stop to run did not load preload value");

endmodule // quadrature_counter

// ===== dv/quad_encoder_model.sv
`timescale 1ns/1ns
module quad_encoder_model
   import qcount_pkg::*;
#(
   parameter int GAP = 6
) (
   input wire logic clock_i,
   output phase_t phase_o,
   output logic strobe_pin_o
);

   // ****************************************************************
   // Encoder phases and the preload/strobe pin.
   // ****************************************************************
   int pos = 0;

   initial begin
      phase_o = '0;
      strobe_pin_o = 1'b0;
   end

   function automatic phase_t pattern(input int p);
      case (p)
         1: return 2'b10;
         2: return 2'b11;
         3: return 2'b01;
         default: return 2'b00;
      endcase
   endfunction

   // Moves n quarter cycles; n of two makes an invalid double change.
   // The bench millisecond is a few clocks, so this gap stays below rate.
   task automatic step(input bit up, input int n);
      @(posedge clock_i);
      pos = up ? (pos + n) % 4 : (pos + 4 - n) % 4;
      phase_o <= pattern(pos);
      repeat (GAP) @(posedge clock_i);
   endtask

   task automatic set_pin(input logic v);
      @(posedge clock_i);
      strobe_pin_o <= v;
      repeat (GAP) @(posedge clock_i);
   endtask

endmodule // quad_encoder_model

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench
   import qcount_pkg::*;
;

   // ****************************************************************
   // Clock, reset, bus and instances.
   // ****************************************************************
   localparam int MS = 4;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic out;
   phase_t phase;
   logic pin;
   int n_fail = 0;
   int n_compared = 0;

   always #10 clk = ~clk;

   quadrature_counter #(.MS_CYCLES(MS)) quadrature_counter_inst (
      .clock_i(clk), .reset_n_i(reset_n),
      .phase_a_i(phase.a), .phase_b_i(phase.b),
      .preload_strobe_input_i(pin),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .counter_driven_output_o(out)
   );

   quad_encoder_model quad_encoder_model_inst (
      .clock_i(clk), .phase_o(phase), .strobe_pin_o(pin)
   );

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic chk_reg(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd_reg(a, d);
      chk(d, e);
   endtask

   task automatic chk_out(input logic e);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({15'h0000, out}, {15'h0000, e});
   endtask

   task automatic mv(input bit up);
      quad_encoder_model_inst.step(up, 1);
   endtask

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_reset();
      logic [3:0] a[10] = '{ADDR_CTRL, ADDR_TIMEBASE, ADDR_HI_LIMIT,
         ADDR_LO_LIMIT, ADDR_ON_PRESET, ADDR_OFF_PRESET, ADDR_PRELOAD,
         ADDR_ACCUM, ADDR_RATE, 4'hE};
      logic [15:0] e[10] = '{16'h0000, 16'h03E8, 16'h7FFF, 16'h0000,
         16'h7FFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      for (int i = 0; i < 10; i++) begin
         chk_reg(a[i], e[i]);
      end
      chk_out(1'b0);
      $display("reset test done");
   endtask

   task automatic t_count();
      wr_reg(ADDR_PRELOAD, 16'h0005);
      mv(1'b1);
      chk_reg(ADDR_ACCUM, 16'h0000);
      wr_reg(ADDR_CTRL, 16'h01E1);
      chk_reg(ADDR_ACCUM, 16'h0005);
      chk_reg(ADDR_CTRL, 16'h01E1);
      repeat (4) mv(1'b1);
      chk_reg(ADDR_ACCUM, 16'h0009);
      quad_encoder_model_inst.step(1'b1, 2);
      chk_reg(ADDR_ACCUM, 16'h0009);
      repeat (2) mv(1'b0);
      chk_reg(ADDR_ACCUM, 16'h0007);
      $display("count test done");
   endtask

   task automatic t_limits();
      logic [15:0] d;
      wr_reg(ADDR_HI_REQ, 16'h000A);
      wr_reg(ADDR_LO_REQ, 16'h0000);
      wr_reg(ADDR_CMD, 16'h0001);
      rd_reg(ADDR_STATUS, d);
      chk(d & 16'h0006, 16'h0002);
      chk_reg(ADDR_HI_LIMIT, 16'h7FFF);
      wr_reg(ADDR_ON_PRESET, 16'h0008);
      wr_reg(ADDR_LO_REQ, 16'hFFFE);
      wr_reg(ADDR_CMD, 16'h0001);
      rd_reg(ADDR_STATUS, d);
      chk(d & 16'h0006, 16'h0000);
      chk_reg(ADDR_HI_LIMIT, 16'h000A);
      chk_reg(ADDR_LO_LIMIT, 16'hFFFE);
      repeat (4) mv(1'b1);
      chk_reg(ADDR_ACCUM, 16'hFFFE);
      mv(1'b0);
      chk_reg(ADDR_ACCUM, 16'h000A);
      mv(1'b0);
      chk_reg(ADDR_ACCUM, 16'h0009);
      $display("limit test done");
   endtask

   task automatic t_output();
      logic [15:0] d;
      bit up[10] = '{1, 0, 0, 0, 0, 0, 1, 1, 0, 0};
      bit ex[10] = '{0, 0, 1, 1, 1, 0, 0, 1, 1, 0};
      wr_reg(ADDR_ON_PRESET, 16'h0002);
      wr_reg(ADDR_OFF_PRESET, 16'h0005);
      wr_reg(ADDR_CTRL, 16'h0023);
      quad_encoder_model_inst.set_pin(1'b1);
      chk_reg(ADDR_ACCUM, 16'h0005);
      chk_out(1'b1);
      rd_reg(ADDR_STATUS, d);
      chk(d & 16'h0001, 16'h0001);
      wr_reg(ADDR_STATUS, 16'h0001);
      rd_reg(ADDR_STATUS, d);
      chk(d & 16'h0001, 16'h0000);
      quad_encoder_model_inst.set_pin(1'b0);
      chk_reg(ADDR_STATUS, 16'h0008);
      for (int i = 0; i < 10; i++) begin
         mv(up[i]);
         chk_out(ex[i]);
      end
      wr_reg(ADDR_CTRL, 16'h0033);
      chk_out(1'b0);
      wr_reg(ADDR_CTRL, 16'h0031);
      chk_out(1'b1);
      wr_reg(ADDR_CTRL, 16'h0012);
      chk_out(1'b1);
      $display("output test done");
   endtask

   task automatic t_strobe();
      wr_reg(ADDR_CTRL, 16'h002D);
      chk_reg(ADDR_ACCUM, 16'h0005);
      quad_encoder_model_inst.set_pin(1'b1);
      mv(1'b1);
      chk_reg(ADDR_STROBE, 16'h0000);
      quad_encoder_model_inst.set_pin(1'b0);
      chk_reg(ADDR_STROBE, 16'h0006);
      chk_reg(ADDR_ACCUM, 16'h0006);
      $display("strobe test done");
   endtask

   task automatic t_rate();
      wr_reg(ADDR_TIMEBASE, 16'h0005);
      chk_reg(ADDR_RATE, 16'h0000);
      repeat (3) mv(1'b1);
      mv(1'b0);
      repeat (20) @(posedge clk);
      chk_reg(ADDR_RATE, 16'h0002);
      chk_reg(ADDR_TIMEBASE, 16'h000A);
      wr_reg(ADDR_TIMEBASE, 16'h000A);
      chk_reg(ADDR_RATE, 16'h0000);
      repeat (3) mv(1'b0);
      repeat (20) @(posedge clk);
      chk_reg(ADDR_RATE, 16'hFFFD);
      wr_reg(ADDR_PRELOAD, 16'h0005);
      chk_reg(ADDR_RATE, 16'hFFFD);
      $display("rate test done");
   endtask

   // ****************************************************************
   // Sequence, watchdog and verdict.
   // ****************************************************************
   task automatic close_out();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_count();
      t_limits();
      t_output();
      t_strobe();
      t_rate();
      close_out();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      close_out();
   end

endmodule // testbench
